// ### imrs_axil.sv
// AXI4-Lite slave front end: one write and one read at a time
// assumes 8-bit registers in the low byte lane of aligned words
`timescale 1ns/10ps
`default_nettype none
`include "imrs_defines.svh"
module imrs_axil
   import imrs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_stb,
   output logic [3:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [3:0] rd_addr,
   input wire logic [7:0] rd_data
);
   imrs_axil_t r_reg;
   imrs_axil_t r_next;

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == `IMRS_CTRL_OFS) || (a == `IMRS_STAT_OFS) ||
         (a == `IMRS_DATA_OFS);
   endfunction

   always_comb
   begin
      r_next = r_reg;
      r_next.wr_stb = 1'b0;
      if (s_axi_awvalid && r_reg.awready)
      begin
         r_next.aw_have = 1'b1;
         r_next.addr_w = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_reg.wready)
      begin
         r_next.w_have = 1'b1;
         r_next.wdat = s_axi_wdata[7:0];
         r_next.wstb_ok = s_axi_wstrb[0];
      end
      if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid)
      begin
         r_next.aw_have = 1'b0;
         r_next.w_have = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = mapped(r_reg.addr_w) ? `IMRS_RESP_OKAY
            : `IMRS_RESP_SLVERR;
         r_next.wr_stb = mapped(r_reg.addr_w) && r_reg.wstb_ok;
      end
      if (r_reg.bvalid && s_axi_bready)
      begin
         r_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && r_reg.arready)
      begin
         r_next.ar_pend = 1'b1;
         r_next.ar_addr = s_axi_araddr;
      end
      if (r_reg.ar_pend)
      begin
         r_next.ar_pend = 1'b0;
         r_next.rvalid = 1'b1;
         r_next.rdata = mapped(r_reg.ar_addr) ? {24'h000000, rd_data}
            : 32'h00000000;
         r_next.rresp = mapped(r_reg.ar_addr) ? `IMRS_RESP_OKAY
            : `IMRS_RESP_SLVERR;
      end
      if (r_reg.rvalid && s_axi_rready)
      begin
         r_next.rvalid = 1'b0;
      end
      r_next.awready = !r_next.aw_have;
      r_next.wready = !r_next.w_have;
      r_next.arready = !r_next.ar_pend && !r_next.rvalid;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;
   assign s_axi_rvalid = r_reg.rvalid;
   assign wr_stb = r_reg.wr_stb;
   assign wr_addr = r_reg.addr_w;
   assign wr_data = r_reg.wdat;
   assign rd_addr = r_reg.ar_addr;
endmodule
`default_nettype wire

// ### imrs_defines.svh
// register map, field positions, status codes and bit timing
// assumes a 20 MHz system clock and 32-bit AXI4-Lite word access
`ifndef IMRS_DEFINES_SVH
`define IMRS_DEFINES_SVH

`define IMRS_ADDR_W 4
`define IMRS_CTRL_OFS 4'h0
`define IMRS_STAT_OFS 4'h4
`define IMRS_DATA_OFS 4'h8

`define IMRS_CTRL_RST 8'h00
`define IMRS_DATA_RST 8'hFF
`define IMRS_PRESC_RST 2'h0

`define IMRS_B_FLAG 7
`define IMRS_B_ACKEN 6
`define IMRS_B_START 5
`define IMRS_B_STOP 4
`define IMRS_B_WCOL 3
`define IMRS_B_EN 2
`define IMRS_B_IE 0

`define IMRS_SC_START 8'h08
`define IMRS_SC_RSTART 8'h10
`define IMRS_SC_AW_ACK 8'h18
`define IMRS_SC_AW_NACK 8'h20
`define IMRS_SC_TX_ACK 8'h28
`define IMRS_SC_TX_NACK 8'h30
`define IMRS_SC_LOST 8'h38
`define IMRS_SC_AR_ACK 8'h40
`define IMRS_SC_AR_NACK 8'h48
`define IMRS_SC_RX_ACK 8'h50
`define IMRS_SC_RX_NACK 8'h58
`define IMRS_SC_NONE 8'hF8

`define IMRS_RESP_OKAY 2'h0
`define IMRS_RESP_SLVERR 2'h2

`define IMRS_CLK_MHZ 20
`define IMRS_HALF_BIT_NS 5000
`define IMRS_HALF_CYC ((`IMRS_HALF_BIT_NS * `IMRS_CLK_MHZ) / 1000)
`define IMRS_QTR_CYC (`IMRS_HALF_CYC / 2)

`endif

// ### imrs_master.sv
// two-wire bus master receiver sequencer with AXI4-Lite registers
// assumes open-drain pads outside; oe_n low pulls the line low
//
// Functional notes
// - master mode starts only after START; address direction bit picks rx/tx
// - the interface runs only while interface enable is one
// - START goes out once the bus is seen idle, never mid-transfer
// - after START the flag is set and status reads 0x08
// - writing one clears the flag and releases the next action
// - after read address and acknowledge, flag set with 0x38, 0x40 or 0x48
// - received byte is in the data register when the flag is set
// - in 0x40/0x50 clearing the flag receives a byte, ack per ack enable
// - byte received with ACK reports 0x50, with NACK reports 0x58
// - the stop request clears itself once STOP has gone out
// - start alone gives repeated START; start and stop give STOP then START
// - repeated START reports 0x10 and keeps ownership of the bus
// - in 0x10 an address with write bit switches to master transmit
// - lost arbitration reports 0x38; releases bus, restarts if start set
// - in 0x48 and 0x58 repeated START, STOP or STOP then START follow
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "imrs_defines.svh"
module imrs_master
   import imrs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   localparam logic [11:0] HALF = 12'(`IMRS_HALF_CYC);
   localparam logic [11:0] QTR = 12'(`IMRS_QTR_CYC);
   localparam logic [4:0] C_NONE = 5'(`IMRS_SC_NONE >> 3);

   imrs_core_t r_reg;
   imrs_core_t r_next;
   logic wr_stb;
   logic [3:0] wr_addr;
   logic [7:0] wr_data;
   logic [3:0] rd_addr;
   logic [7:0] rd_data;
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic arb_bit;

   imrs_axil u_axil (
      .clk(clk),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   imrs_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in({scl_i, sda_i}),
      .pin_sync(pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // driven bits that another master may override
   assign arb_bit = (r_reg.ph == PH_RX) ? (r_reg.bitn == 4'd8)
      : (r_reg.bitn < 4'd8);

   assign rd_data = (rd_addr == `IMRS_CTRL_OFS) ?
      {r_reg.flag, r_reg.ack_en, r_reg.start_req, r_reg.stop_req,
       r_reg.wcol, r_reg.en, 1'b0, r_reg.ie}
      : (rd_addr == `IMRS_STAT_OFS) ?
      {r_reg.code, 1'b0, r_reg.presc}
      : r_reg.data;

   always_comb
   begin
      r_next = r_reg;
      // software writes first, so a hardware set in the same cycle wins
      if (wr_stb && (wr_addr == `IMRS_CTRL_OFS))
      begin
         if (wr_data[`IMRS_B_FLAG])
         begin
            r_next.flag = 1'b0;
         end
         r_next.ack_en = wr_data[`IMRS_B_ACKEN];
         r_next.start_req = wr_data[`IMRS_B_START];
         r_next.stop_req = wr_data[`IMRS_B_STOP];
         r_next.en = wr_data[`IMRS_B_EN];
         r_next.ie = wr_data[`IMRS_B_IE];
      end
      else if (wr_stb && (wr_addr == `IMRS_STAT_OFS))
      begin
         r_next.presc = wr_data[1:0];
      end
      else if (wr_stb && (wr_addr == `IMRS_DATA_OFS))
      begin
         // data may only change while the bus is stalled
         if (r_reg.flag)
         begin
            r_next.data = wr_data;
            r_next.wcol = 1'b0;
         end
         else
         begin
            r_next.wcol = 1'b1;
         end
      end

      // bus free/busy tracking from START and STOP seen on the lines
      r_next.last_scl = scl_s;
      r_next.last_sda = sda_s;
      if (scl_s && r_reg.last_scl && r_reg.last_sda && !sda_s)
      begin
         r_next.busy = 1'b1;
      end
      if (scl_s && r_reg.last_scl && !r_reg.last_sda && sda_s)
      begin
         r_next.busy = 1'b0;
      end

      r_next.cnt = 12'(r_reg.cnt + 12'd1);
      if (!r_reg.en)
      begin
         r_next.st = S_IDLE;
         r_next.scl_oe_n = 1'b1;
         r_next.sda_oe_n = 1'b1;
         r_next.owned = 1'b0;
      end
      else
      begin
         unique case (r_reg.st)
            S_IDLE:
            begin
               r_next.scl_oe_n = 1'b1;
               r_next.sda_oe_n = 1'b1;
               if (!r_reg.flag && r_reg.start_req && !r_reg.busy)
               begin
                  r_next.st = S_START_HI;
                  r_next.cnt = 12'd0;
               end
            end
            S_START_HI:
            begin
               if (!scl_s)
               begin
                  r_next.cnt = 12'd0;
               end
               else if (r_reg.cnt == HALF)
               begin
                  r_next.sda_oe_n = 1'b0;
                  r_next.st = S_START_LO;
                  r_next.cnt = 12'd0;
               end
            end
            S_START_LO:
            begin
               if (r_reg.cnt == HALF)
               begin
                  r_next.scl_oe_n = 1'b0;
                  r_next.flag = 1'b1;
                  r_next.code = r_reg.owned ? 5'(`IMRS_SC_RSTART >> 3)
                     : 5'(`IMRS_SC_START >> 3);
                  r_next.owned = 1'b1;
                  r_next.st = S_HOLD;
               end
            end
            S_HOLD:
            begin
               // clock stays low while owned and the flag is set
               if (!r_reg.flag)
               begin
                  r_next.cnt = 12'd0;
                  if (!r_reg.owned)
                  begin
                     r_next.st = S_IDLE;
                  end
                  else if (r_reg.stop_req)
                  begin
                     r_next.sda_oe_n = 1'b0;
                     r_next.st = S_STOP_LO;
                  end
                  else if (r_reg.start_req)
                  begin
                     r_next.sda_oe_n = 1'b1;
                     r_next.st = S_RS_LO;
                  end
                  else
                  begin
                     r_next.st = S_BIT_LO;
                     r_next.bitn = 4'd0;
                     if ((r_reg.code == `IMRS_SC_START >> 3) ||
                        (r_reg.code == `IMRS_SC_RSTART >> 3))
                     begin
                        r_next.sh = {r_reg.data, 1'b1};
                        r_next.mode_rx = r_reg.data[0];
                        r_next.ph = PH_ADDR;
                     end
                     else if (r_reg.mode_rx)
                     begin
                        r_next.sh = {8'hFF, !r_reg.ack_en};
                        r_next.ph = PH_RX;
                     end
                     else
                     begin
                        r_next.sh = {r_reg.data, 1'b1};
                        r_next.ph = PH_TX;
                     end
                  end
               end
            end
            S_RS_LO:
            begin
               if (r_reg.cnt == HALF)
               begin
                  r_next.scl_oe_n = 1'b1;
                  r_next.st = S_START_HI;
                  r_next.cnt = 12'd0;
               end
            end
            S_STOP_LO:
            begin
               if (r_reg.cnt == HALF)
               begin
                  r_next.scl_oe_n = 1'b1;
                  r_next.st = S_STOP_HI;
                  r_next.cnt = 12'd0;
               end
            end
            S_STOP_HI:
            begin
               if (!scl_s)
               begin
                  r_next.cnt = 12'd0;
               end
               else if (r_reg.cnt == HALF)
               begin
                  r_next.sda_oe_n = 1'b1;
                  r_next.st = S_STOP_END;
                  r_next.cnt = 12'd0;
               end
            end
            S_STOP_END:
            begin
               if (r_reg.cnt == HALF)
               begin
                  r_next.stop_req = 1'b0;
                  r_next.owned = 1'b0;
                  r_next.code = C_NONE;
                  r_next.st = S_IDLE;
               end
            end
            S_BIT_LO:
            begin
               if (r_reg.cnt == QTR)
               begin
                  r_next.sda_oe_n = r_reg.sh[8];
               end
               if (r_reg.cnt == HALF)
               begin
                  r_next.scl_oe_n = 1'b1;
                  r_next.st = S_BIT_HI;
                  r_next.cnt = 12'd0;
               end
            end
            S_BIT_HI:
            begin
               if (!scl_s)
               begin
                  r_next.cnt = 12'd0;
               end
               else if ((r_reg.cnt == QTR) && r_reg.sh[8] && !sda_s &&
                  arb_bit)
               begin
                  r_next.scl_oe_n = 1'b1;
                  r_next.sda_oe_n = 1'b1;
                  r_next.owned = 1'b0;
                  r_next.flag = 1'b1;
                  r_next.code = 5'(`IMRS_SC_LOST >> 3);
                  r_next.bitn = 4'd0;
                  r_next.st = S_HOLD;
               end
               else if (r_reg.cnt == QTR)
               begin
                  r_next.smp = sda_s;
               end
               else if (r_reg.cnt == HALF)
               begin
                  r_next.scl_oe_n = 1'b0;
                  r_next.cnt = 12'd0;
                  r_next.rx = {r_reg.rx[7:0], r_reg.smp};
                  r_next.sh = {r_reg.sh[7:0], 1'b1};
                  r_next.bitn = 4'(r_reg.bitn + 4'd1);
                  r_next.st = S_BIT_LO;
                  if (r_reg.bitn == 4'd8)
                  begin
                     r_next.bitn = 4'd0;
                     r_next.flag = 1'b1;
                     r_next.st = S_HOLD;
                     unique case (r_reg.ph)
                        PH_ADDR:
                        begin
                           if (r_reg.mode_rx)
                           begin
                              r_next.code = !r_reg.smp ?
                                 5'(`IMRS_SC_AR_ACK >> 3)
                                 : 5'(`IMRS_SC_AR_NACK >> 3);
                           end
                           else
                           begin
                              r_next.code = !r_reg.smp ?
                                 5'(`IMRS_SC_AW_ACK >> 3)
                                 : 5'(`IMRS_SC_AW_NACK >> 3);
                           end
                        end
                        PH_RX:
                        begin
                           r_next.data = r_reg.rx[7:0];
                           r_next.code = r_reg.sh[8] ?
                              5'(`IMRS_SC_RX_NACK >> 3)
                              : 5'(`IMRS_SC_RX_ACK >> 3);
                        end
                        default:
                        begin
                           r_next.code = !r_reg.smp ?
                              5'(`IMRS_SC_TX_ACK >> 3)
                              : 5'(`IMRS_SC_TX_NACK >> 3);
                        end
                     endcase
                  end
               end
            end
            default:
            begin
               r_next.st = S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r_reg <= '{st: S_IDLE, cnt: 12'h000, flag: 1'b0,
            ack_en: 1'b0, start_req: 1'b0, stop_req: 1'b0, wcol: 1'b0,
            en: 1'b0, ie: 1'b0, presc: `IMRS_PRESC_RST,
            code: C_NONE, data: `IMRS_DATA_RST, sh: 9'h1FF,
            rx: 9'h000, bitn: 4'h0, ph: PH_ADDR, mode_rx: 1'b0,
            owned: 1'b0, busy: 1'b0, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
            last_scl: 1'b1, last_sda: 1'b1, smp: 1'b1};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // open-drain: the pad only ever pulls low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n = r_reg.scl_oe_n;
   assign sda_oe_n = r_reg.sda_oe_n;
endmodule
`default_nettype wire

// ### imrs_master_checker.sv
// port assertions for the two-wire master receiver
// assumes binding onto imrs_master, pins read at the pads
`timescale 1ns/10ps
`default_nettype none
module imrs_master_checker
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic scl_oe_n,
   input wire logic sda_oe_n
);
   logic [3:0] ra_reg = 4'h0;
   wire logic rd_st = s_axi_rvalid && ra_reg == 4'h4;
   wire logic rd_ct = s_axi_rvalid && ra_reg == 4'h0;
   always_ff @(posedge clk)
      if (s_axi_arvalid && s_axi_arready)
         ra_reg <= s_axi_araddr;
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_pins_free_rst: assert property ($fell(sys_rst) |-> scl_oe_n && sda_oe_n)
      else $error("pins driven after reset");
   a_off_released: assert property (rd_ct && !s_axi_rdata[2] |->
      scl_oe_n && sda_oe_n) else $error("pins driven while off");
   a_start_on_idle: assert property ($fell(sda_oe_n) && scl_oe_n |->
      $past(sda_i) && scl_i) else $error("start on busy lines");
   a_clk_held_flag: assert property (rd_ct && s_axi_rdata[7] &&
      s_axi_rdata[2] |-> !scl_oe_n) else $error("clock free with flag");
   a_status_layout: assert property (rd_st |-> s_axi_rdata[31:8] == 24'h0
      && !s_axi_rdata[2]) else $error("status layout wrong");
   a_status_codes: assert property (rd_st |-> s_axi_rdata[7:3] inside
      {[5'h01:5'h0B], 5'h1F}) else $error("status code unknown");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
      ##[1:3] s_axi_rvalid) else $error("read not answered");
endmodule
bind imrs_master imrs_master_checker imrs_master_checker_inst (.*);
`default_nettype wire

// ### imrs_master_tb.sv
// self-checking bench for the two-wire master receiver
// assumes the slave model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
module imrs_master_tb;
   localparam logic [6:0] SADR = 7'h2A;
   logic clk = 1'b0, sys_rst = 1'b1, stretch = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_drv, sda_drv;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   wire logic scl_i = (scl_oe_n | scl_o) & scl_drv;
   wire logic sda_i = (sda_oe_n | sda_o) & sda_drv;
   int miscompares = 0, checked = 0;
   logic [37:0] row [4] = '{{4'h0, 2'h0, 32'h00}, {4'h4, 2'h0, 32'hF8},
      {4'h8, 2'h0, 32'hFF}, {4'hC, 2'h2, 32'h00}};
   imrs_master imrs_master_inst (.*);
   imrs_slave_model #(.ADDR(SADR)) imrs_slave_model_inst (.scl(scl_i),
      .sda(sda_i), .stretch(stretch), .sda_drv(sda_drv), .scl_drv(scl_drv));
   initial
      forever #25 clk = ~clk;
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // poll until the flag is up, then compare the masked status code
   task automatic st(input logic [7:0] c);
      d = 32'h0;
      while (!d[7])
         rd(4'h0);
      chk({33'h0, scl_i}, 34'h0);
      rd(4'h4);
      chk({2'h0, d & 32'hF8}, {26'h0, c});
   endtask
   task automatic end_of_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #4000000;
      miscompares++;
      end_of_test;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (row[i])
      begin
         rd(row[i][37:34]);
         chk({rr, d}, row[i][33:0]);
      end
      wr(4'h0, 8'hA4);
      st(8'h08);
      wr(4'h8, {SADR, 1'b1});
      wr(4'h0, 8'hC4);
      st(8'h40);
      stretch <= 1'b1;
      wr(4'h0, 8'hC4);
      st(8'h50);
      rd(4'h8);
      chk({2'h0, d}, 34'hA5);
      stretch <= 1'b0;
      wr(4'h0, 8'h84);
      st(8'h58);
      rd(4'h8);
      chk({2'h0, d}, 34'h5A);
      wr(4'h0, 8'hA4);
      st(8'h10);
      wr(4'h8, {~SADR, 1'b1});
      wr(4'h0, 8'h84);
      st(8'h48);
      wr(4'h0, 8'hB4);
      st(8'h08);
      rd(4'h0);
      chk({2'h0, d & 32'h10}, 34'h0);
      wr(4'h8, {SADR, 1'b0});
      wr(4'h0, 8'h84);
      st(8'h18);
      wr(4'h0, 8'h94);
      d = 32'h10;
      while (d[4])
         rd(4'h0);
      rd(4'h4);
      chk({2'h0, d}, 34'hF8);
      chk({32'h0, scl_i, sda_i}, 34'h3);
      // mid-run reset must bring the status and data registers back to their idle values
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(4'h4);
      chk({rr, d}, 34'hF8);
      rd(4'h8);
      chk({rr, d}, 34'hFF);
      end_of_test;
   end
endmodule
`default_nettype wire

// ### imrs_pkg.sv
// types shared by the two-wire master receiver sequencer
// assumes nothing beyond the synthesis tool's SystemVerilog support
package imrs_pkg;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_START_HI = 4'h1,
      S_START_LO = 4'h2,
      S_BIT_LO = 4'h3,
      S_BIT_HI = 4'h4,
      S_HOLD = 4'h5,
      S_STOP_LO = 4'h6,
      S_STOP_HI = 4'h7,
      S_STOP_END = 4'h8,
      S_RS_LO = 4'h9
   } imrs_state_t;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_RX = 2'h1,
      PH_TX = 2'h2
   } imrs_phase_t;

   typedef struct packed {
      imrs_state_t st;
      logic [11:0] cnt;
      logic flag;
      logic ack_en;
      logic start_req;
      logic stop_req;
      logic wcol;
      logic en;
      logic ie;
      logic [1:0] presc;
      logic [4:0] code;
      logic [7:0] data;
      logic [8:0] sh;
      logic [8:0] rx;
      logic [3:0] bitn;
      imrs_phase_t ph;
      logic mode_rx;
      logic owned;
      logic busy;
      logic scl_oe_n;
      logic sda_oe_n;
      logic last_scl;
      logic last_sda;
      logic smp;
   } imrs_core_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [3:0] addr_w;
      logic [7:0] wdat;
      logic wstb_ok;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic ar_pend;
      logic [3:0] ar_addr;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic wr_stb;
   } imrs_axil_t;

   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] stable;
   } imrs_sync_t;

endpackage

// ### imrs_slave_model.sv
// slave transmitter model for the two-wire bus
// assumes open-drain lines with pull-ups made in the bench
`timescale 1ns/10ps
`default_nettype none
module imrs_slave_model #(parameter logic [6:0] ADDR = 7'h2A)
(
   input wire logic scl,
   input wire logic sda,
   input wire logic stretch,
   output logic sda_drv = 1'b1,
   output logic scl_drv = 1'b1
);
   logic [7:0] sh = 8'h0;
   logic [7:0] tx = 8'hA5;
   logic adr = 1'b0;
   logic rdm = 1'b0;
   int n = 0;
   // start or repeated start restarts the address byte
   always @(negedge sda)
      if (scl)
         {n, adr, rdm} = {32'd0, 2'b10};
   always @(posedge sda)
      if (scl)
         {adr, rdm} = 2'b00;
   always @(posedge scl)
   begin
      if (n < 8)
         sh = {sh[6:0], sda};
      else if (adr)
         {adr, rdm} = {1'b0, sh == {ADDR, 1'b1}};
      else if (rdm)
         {rdm, tx} = {!sda, ~tx};
      n = (n == 8) ? 0 : n + 1;
   end
   always @(negedge scl)
   begin
      #100;
      if (adr && n == 8)
         sda_drv = sh[7:1] != ADDR;
      else
         sda_drv = !rdm || n == 8 || tx[7 - n];
      // optional slow answer: hold the clock low a while
      if (stretch)
      begin
         scl_drv = 1'b0;
         #20000 scl_drv = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### imrs_sync.sv
// two-stage synchroniser for the serial clock and data pin inputs
// assumes the pins idle high, so the stages reset to one
`timescale 1ns/10ps
`default_nettype none
module imrs_sync
   import imrs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] pin_in,
   output logic [1:0] pin_sync
);
   imrs_sync_t r_reg;
   imrs_sync_t r_next;

   always_comb
   begin
      r_next = r_reg;
      r_next.meta = pin_in;
      r_next.stable = r_reg.meta;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r_reg <= '{meta: 2'h3, stable: 2'h3};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign pin_sync = r_reg.stable;
endmodule
`default_nettype wire
